// ---- timer0_defs.svh ----
// Offsets, field positions, reset values and timing counts of the timer block.
`ifndef TIMER0_DEFS_SVH
`define TIMER0_DEFS_SVH

// -----------------------------------------------------------------------------
// Register indices and byte addresses
// -----------------------------------------------------------------------------
`define IDX_COUNT        12'h001
`define IDX_OPTION       12'h002
`define IDX_INTCTL       12'h00B
`define IDX_INTCTL_ALT   12'h08B
`define ADR_COUNT        (`IDX_COUNT * 12'h004)
`define ADR_OPTION       (`IDX_OPTION * 12'h004)
`define ADR_INTCTL       (`IDX_INTCTL * 12'h004)
`define ADR_INTCTL_ALT   (`IDX_INTCTL_ALT * 12'h004)

// -----------------------------------------------------------------------------
// Option register fields
// -----------------------------------------------------------------------------
`define OPT_SRC_SEL      5
`define OPT_EDGE_SEL     4
`define OPT_PRE_ASSIGN   3
`define OPT_RATIO_HI     2
`define OPT_RATIO_LO     0
`define OPT_RESET        8'hFF

// -----------------------------------------------------------------------------
// Interrupt control register fields
// -----------------------------------------------------------------------------
`define IC_GLOBAL_EN     7
`define IC_PERIPH_EN     6
`define IC_OVF_EN        5
`define IC_EXT_EN        4
`define IC_PORT_EN       3
`define IC_OVF_FLAG      2
`define IC_EXT_FLAG      1
`define IC_PORT_FLAG     0
`define IC_RESET         8'h00

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define COUNT_RESET      8'h00
`define COUNT_MAX        8'hFF
`define WRITE_INHIBIT    2'h2

`endif

// ---- timer0_pkg.sv ----
// Types shared by the timer block.
package timer0_pkg;

  // ---------------------------------------------------------------------------
  // Count source
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_CYCLE = 2'b01,
    SRC_PIN   = 2'b10
  } src_mode_t;

endpackage : timer0_pkg

// ---- timer0_counter.sv ----
// Eight-bit timer/counter with shared prescaler behind a classic Wishbone slave.
`include "timer0_defs.svh"
`timescale 1ns/1ps

module timer0_counter #(
  parameter int ADR_W = 12                      // Wishbone address width
) (
  input  wire logic             clk_i,           // Instruction-cycle clock
  input  wire logic             rst_i,           // Synchronous reset, active high
  input  wire logic             cyc_i,           // Wishbone cycle
  input  wire logic             stb_i,           // Wishbone strobe
  input  wire logic             we_i,            // Wishbone write enable
  input  wire logic [ADR_W-1:0] adr_i,           // Wishbone byte address
  input  wire logic [3:0]       sel_i,           // Wishbone byte select
  input  wire logic [31:0]      dat_i,           // Wishbone write data
  output logic      [31:0]      dat_o,           // Wishbone read data
  output logic                  ack_o,           // Wishbone acknowledge
  input  wire logic             count_pin_i,     // External count pin, asynchronous
  input  wire logic             sleep_i,         // Core is asleep
  input  wire logic             ext_irq_event_i, // External interrupt pin event
  input  wire logic             port_change_i,   // Port change event
  input  wire logic             wdt_tick_i,      // Raw watchdog tick
  output logic                  wdt_tick_o,      // Watchdog tick, after prescaler only when it is assigned to the watchdog
  output logic                  irq_o,           // Interrupt request to the core
  output logic      [7:0]       count_o          // Current count value
);
  import timer0_pkg::*;

  // ---------------------------------------------------------------------------
  // Registers and bus decode
  // ---------------------------------------------------------------------------
  logic [7:0]  count_q;
  logic [7:0]  option_q;
  logic [7:0]  intctl_q;
  logic [7:0]  pre_q;
  logic [1:0]  inhibit_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        pin_s1_q;
  logic        pin_s2_q;
  logic        pin_prev_q;
  logic        wdt_q;

  logic        req;
  logic        wr_commit;
  logic        hit_count;
  logic        hit_option;
  logic        hit_intctl;
  logic        cnt_wr;
  logic        opt_wr;
  logic        ic_wr;
  logic [7:0]  rd_byte;
  logic [7:0]  wdat;

  assign req        = cyc_i && stb_i;
  // Writes commit on the edge where ack is seen high, as the master expects.
  assign wr_commit  = req && we_i && ack_q && sel_i[0];
  assign hit_count  = (adr_i == ADR_W'(`ADR_COUNT));
  assign hit_option = (adr_i == ADR_W'(`ADR_OPTION));
  assign hit_intctl = (adr_i == ADR_W'(`ADR_INTCTL)) ||
                      (adr_i == ADR_W'(`ADR_INTCTL_ALT));
  assign cnt_wr     = wr_commit && hit_count;
  assign opt_wr     = wr_commit && hit_option;
  assign ic_wr      = wr_commit && hit_intctl;
  assign wdat       = dat_i[7:0];

  // The prescaler has no address at all, so software can never see it.
  always_comb begin
    rd_byte = 8'h00;
    if (hit_count) begin
      rd_byte = count_q;
    end else if (hit_option) begin
      rd_byte = option_q;
    end else if (hit_intctl) begin
      rd_byte = intctl_q;
    end
  end

  // One wait state: ack follows the request edge, drops in the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req && !ack_q;
      if (req && !ack_q) begin
        dat_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      option_q <= `OPT_RESET;
    end else if (opt_wr) begin
      option_q <= wdat;
    end
  end

  // ---------------------------------------------------------------------------
  // Count source and edge detect
  // ---------------------------------------------------------------------------
  src_mode_t   src_mode;
  logic        pin_rise;
  logic        pin_fall;
  logic        src_event;
  logic        pre_to_wdt;
  logic        pre_src;
  logic [2:0]  ratio;
  logic [7:0]  pre_mask;
  logic        pre_tick;
  logic        tick;
  logic        inc;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q   <= 1'b0;
      pin_s2_q   <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_s1_q   <= count_pin_i;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  assign src_mode = option_q[`OPT_SRC_SEL] ? SRC_PIN : SRC_CYCLE;
  assign pin_rise = pin_s2_q && !pin_prev_q;
  assign pin_fall = !pin_s2_q && pin_prev_q;

  always_comb begin
    case (src_mode)
      SRC_CYCLE: src_event = 1'b1;
      SRC_PIN:   src_event = option_q[`OPT_EDGE_SEL] ? pin_fall : pin_rise;
      default:   src_event = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Shared prescaler
  // ---------------------------------------------------------------------------
  assign pre_to_wdt = option_q[`OPT_PRE_ASSIGN];
  assign pre_src    = pre_to_wdt ? wdt_tick_i : src_event;
  assign ratio      = option_q[`OPT_RATIO_HI:`OPT_RATIO_LO];
  assign pre_mask   = 8'((9'h002 << ratio) - 9'h001);
  assign pre_tick   = pre_src && !sleep_i && ((pre_q & pre_mask) == pre_mask);

  // A count write also clears the prescaler while it is assigned to the timer, so the new count starts clean.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= 8'h00;
    end else if (cnt_wr && !pre_to_wdt) begin
      pre_q <= 8'h00;
    end else if (pre_src && !sleep_i) begin
      pre_q <= pre_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_q <= 1'b0;
    end else begin
      wdt_q <= pre_to_wdt ? pre_tick : wdt_tick_i;
    end
  end

  assign wdt_tick_o = wdt_q;

  // ---------------------------------------------------------------------------
  // Count register
  // ---------------------------------------------------------------------------
  assign tick = pre_to_wdt ? src_event : pre_tick;
  assign inc  = tick && !sleep_i && (inhibit_q == 2'h0) && !cnt_wr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inhibit_q <= 2'h0;
    end else if (cnt_wr) begin
      inhibit_q <= `WRITE_INHIBIT;
    end else if (inhibit_q != 2'h0) begin
      inhibit_q <= inhibit_q - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= `COUNT_RESET;
    end else if (cnt_wr) begin
      count_q <= wdat;
    end else if (inc) begin
      count_q <= count_q + 8'h01;
    end
  end

  assign count_o = count_q;

  // ---------------------------------------------------------------------------
  // Interrupt control
  // ---------------------------------------------------------------------------
  logic       overflow;
  logic [7:0] ic_set;

  assign overflow = inc && (count_q == `COUNT_MAX);
  assign ic_set   = {5'h00, overflow, ext_irq_event_i, port_change_i};

  // A flag event in the same cycle as a software clear wins over the clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intctl_q <= `IC_RESET;
    end else if (ic_wr) begin
      intctl_q <= wdat | ic_set;
    end else begin
      intctl_q <= intctl_q | ic_set;
    end
  end

  assign irq_o = intctl_q[`IC_GLOBAL_EN] &&
    ((intctl_q[`IC_OVF_EN] && intctl_q[`IC_OVF_FLAG]) ||
     (intctl_q[`IC_EXT_EN] && intctl_q[`IC_EXT_FLAG]) ||
     (intctl_q[`IC_PORT_EN] && intctl_q[`IC_PORT_FLAG]));

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_count_write;
    cnt_wr ##1 !cnt_wr;
  endsequence

  property p_timer_step;
    @(posedge clk_i) disable iff (rst_i)
    (src_mode == SRC_CYCLE && pre_to_wdt && !sleep_i && inhibit_q == 2'h0 && !cnt_wr)
      |=> count_q == 8'($past(count_q) + 8'h01);
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer did not step");

  property p_write_hold;
    @(posedge clk_i) disable iff (rst_i)
    s_count_write |-> (count_q == $past(wdat, 1)) ##1 (cnt_wr || $stable(count_q))
      ##1 ($past(cnt_wr) || $stable(count_q));
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("count moved after write");

  property p_pin_step;
    @(posedge clk_i) disable iff (rst_i)
    (src_mode == SRC_PIN && pre_to_wdt && !sleep_i && inhibit_q == 2'h0 && !cnt_wr &&
     (option_q[`OPT_EDGE_SEL] ? pin_fall : pin_rise)) |=> count_q == 8'($past(count_q) + 8'h01);
  endproperty
  a_pin_step: assert property (p_pin_step) else $error("pin edge not counted");

  property p_pin_idle;
    @(posedge clk_i) disable iff (rst_i)
    (src_mode == SRC_PIN && !cnt_wr && !pin_rise && !pin_fall) |=> $stable(count_q);
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("count moved without edge");

  property p_prescaled;
    @(posedge clk_i) disable iff (rst_i)
    (!pre_to_wdt && !cnt_wr && !pre_tick) |=> $stable(count_q);
  endproperty
  a_prescaled: assert property (p_prescaled) else $error("count moved without pulse");

  property p_ovf_flag;
    @(posedge clk_i) disable iff (rst_i)
    overflow |=> intctl_q[`IC_OVF_FLAG] && count_q == 8'h00;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

  property p_flag_hold;
    @(posedge clk_i) disable iff (rst_i)
    (intctl_q[`IC_OVF_FLAG] && !ic_wr) |=> intctl_q[`IC_OVF_FLAG];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("overflow flag lost");

  property p_irq_mask;
    @(posedge clk_i) disable iff (rst_i)
    (!intctl_q[`IC_OVF_EN] && !intctl_q[`IC_EXT_FLAG] && !intctl_q[`IC_PORT_FLAG]) |-> !irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked request raised");

  property p_sleep_stop;
    @(posedge clk_i) disable iff (rst_i)
    (sleep_i && !cnt_wr && !ic_wr) |=> $stable(count_q) && !$rose(intctl_q[`IC_OVF_FLAG]);
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("count moved in sleep");

  property p_bus_ack;
    @(posedge clk_i) disable iff (rst_i)
    (req && !ack_q) |=> ack_o ##1 !ack_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("ack timing wrong");

endmodule : timer0_counter

// ---- count_pin_model.sv ----
// Behavioural source that drives the external count pin.
`timescale 1ns/1ps

module count_pin_model (
  input  wire logic clk_i, // Instruction-cycle clock
  output logic      pin_o  // Level driven onto the count pin
);
  initial pin_o = 1'b0;

  // Levels move just after a clock edge, so the pin synchroniser never sees a tie.
  task automatic set_level(input logic lvl);
    @(posedge clk_i);
    pin_o <= lvl;
  endtask : set_level
endmodule : count_pin_model

// ---- test_timer0_counter.sv ----
// Self-checking bench of the timer/counter register and count behaviour.
`include "timer0_defs.svh"
`timescale 1ns/1ps

module test_timer0_counter;
  import timer0_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [11:0] adr_i = '0;
  logic [3:0]  sel_i = '0;
  logic [31:0] dat_i = '0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        count_pin_i;
  logic        sleep_i = 1'b0;
  logic        ext_irq_event_i = 1'b0;
  logic        port_change_i = 1'b0;
  logic        wdt_tick_i = 1'b0;
  logic        wdt_tick_o;
  logic        irq_o;
  logic [7:0]  count_o;
  logic [31:0] rdat;
  logic [7:0]  held;
  int          gap;
  int          pulses;
  int          miscompares = 0;
  int          checked = 0;

  always #20 clk_i = ~clk_i;

  timer0_counter timer0_counter_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .count_pin_i(count_pin_i), .sleep_i(sleep_i), .ext_irq_event_i(ext_irq_event_i),
    .port_change_i(port_change_i), .wdt_tick_i(wdt_tick_i), .wdt_tick_o(wdt_tick_o),
    .irq_o(irq_o), .count_o(count_o));

  count_pin_model count_pin_model_i (.clk_i(clk_i), .pin_o(count_pin_i));

  // ---------------------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Write commits and read data is taken at the edge where ack is seen high.
  task automatic bus(input logic wr, input logic [11:0] adr, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= adr;
    sel_i <= 4'hF;
    dat_i <= {24'h000000, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("ERROR bus ack expected 1 seen %0h", ack_o);
      report_and_stop();
    end
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : bus

  // Cycles between two successive count changes; bounded so a stuck count ends the run.
  task automatic gap_of(output int g);
    logic [7:0] v;
    int         k;
    @(posedge clk_i);
    #1 v = count_o;
    k = 0;
    while (count_o === v && k < 600) begin
      @(posedge clk_i);
      #1 k++;
    end
    v = count_o;
    g = 0;
    while (count_o === v && g < 600) begin
      @(posedge clk_i);
      #1 g++;
    end
    if (k >= 600 || g >= 600) begin
      miscompares++;
      $display("ERROR count change expected change seen %0h", count_o);
      report_and_stop();
    end
  endtask : gap_of

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, `ADR_OPTION, 8'h00);
    chk("option reset", 32'hFF, rdat);
    bus(1'b0, `ADR_INTCTL, 8'h00);
    chk("intctl reset", 32'h00, rdat);
    bus(1'b0, 12'h3FC, 8'h00);
    chk("unmapped read", 32'h00, rdat);
    $display("test reset done");

    bus(1'b1, `ADR_OPTION, 8'h08);
    bus(1'b1, `ADR_COUNT, 8'hFE);
    #1 chk("count at write", 32'hFE, count_o);
    for (int i = 1; i <= 4; i++) begin
      @(posedge clk_i);
      #1 chk("count walk", (i < 3) ? 32'hFE : (i == 3) ? 32'hFF : 32'h00, count_o);
    end
    repeat (10) @(posedge clk_i);
    #1 chk("count free run", 32'h0A, count_o);
    bus(1'b0, `ADR_INTCTL, 8'h00);
    chk("overflow flag", 32'h04, rdat);
    chk("irq masked", 32'h0, irq_o);
    @(posedge clk_i);
    sleep_i <= 1'b1;
    @(posedge clk_i);
    #1 held = count_o;
    repeat (300) @(posedge clk_i);
    #1 chk("count in sleep", held, count_o);
    bus(1'b0, `ADR_INTCTL, 8'h00);
    chk("flag held", 32'h04, rdat);
    bus(1'b1, `ADR_INTCTL, 8'hA4);
    #1 chk("irq enabled", 32'h1, irq_o);
    bus(1'b1, `ADR_INTCTL, 8'h84);
    #1 chk("irq ovf disabled", 32'h0, irq_o);
    bus(1'b1, `ADR_INTCTL, 8'hA0);
    #1 chk("irq after clear", 32'h0, irq_o);
    bus(1'b0, `ADR_INTCTL, 8'h00);
    chk("intctl rw", 32'hA0, rdat);
    @(posedge clk_i);
    sleep_i <= 1'b0;
    $display("test timer done");

    for (int n = 0; n < 8; n++) begin
      bus(1'b1, `ADR_OPTION, 8'(n));
      gap_of(gap);
      chk("prescale gap", 32'(1 << (n + 1)), 32'(gap));
    end
    @(posedge clk_i);
    wdt_tick_i <= 1'b1;
    @(posedge clk_i);
    wdt_tick_i <= 1'b0;
    #1 chk("wdt raw tick", 32'h1, wdt_tick_o);
    // With the prescaler on the watchdog at 1:2, four raw ticks give two output ticks.
    bus(1'b1, `ADR_OPTION, 8'h08);
    pulses = 0;
    for (int t = 0; t < 8; t++) begin
      @(posedge clk_i);
      wdt_tick_i <= (t % 2 == 0);
      #1 pulses += (wdt_tick_o === 1'b1) ? 1 : 0;
    end
    chk("wdt prescaled", 32'h2, 32'(pulses));
    $display("test prescaler done");

    for (int e = 0; e < 2; e++) begin
      bus(1'b1, `ADR_OPTION, 8'h28 | 8'(e << 4));
      bus(1'b1, `ADR_COUNT, 8'h00);
      count_pin_model_i.set_level(1'b1);
      repeat (6) @(posedge clk_i);
      #1 chk("pin rise", (e == 0) ? 32'h1 : 32'h0, count_o);
      count_pin_model_i.set_level(1'b0);
      repeat (6) @(posedge clk_i);
      #1 chk("pin fall", 32'h1, count_o);
    end
    bus(1'b1, `ADR_INTCTL, 8'h00);
    @(posedge clk_i);
    ext_irq_event_i <= 1'b1;
    port_change_i   <= 1'b1;
    @(posedge clk_i);
    ext_irq_event_i <= 1'b0;
    port_change_i   <= 1'b0;
    bus(1'b0, `ADR_INTCTL_ALT, 8'h00);
    chk("other flags", 32'h03, rdat);
    bus(1'b1, `ADR_INTCTL, 8'h92);
    #1 chk("irq ext", 32'h1, irq_o);
    bus(1'b1, `ADR_INTCTL, 8'h89);
    #1 chk("irq port", 32'h1, irq_o);
    bus(1'b1, `ADR_INTCTL, 8'h88);
    #1 chk("irq port cleared", 32'h0, irq_o);
    $display("test counter done");
    report_and_stop();
  end
endmodule : test_timer0_counter
